// File: hw/gie_pkg.sv
package giei_pkg;
  localparam int          SW_W         = 16;
  localparam logic [15:0] IRQ_EN_MASK  = 16'h0008;
  localparam logic [15:0] IRQ_CLR_MASK = 16'hFFF7;
  localparam logic [15:0] STATUS_RST   = 16'h0000;
  localparam int          IRQ_EN_BIT   = 3;
  typedef enum logic [2:0] {
    OP_NONE = 3'h1,
    OP_CLR  = 3'h2,
    OP_SET  = 3'h4
  } giei_op_t;
endpackage : giei_pkg

// File: hw/gie_alu_if.sv
`timescale 1ns/1ps
interface giei_alu_if;
  logic [giei_pkg::SW_W-1:0] status_in;
  logic [giei_pkg::SW_W-1:0] status_out;
  logic                      do_clr;
  logic                      do_set;
  modport core (output status_in, output do_clr, output do_set, input status_out);
  modport alu  (input status_in, input do_clr, input do_set, output status_out);
endinterface : giei_alu_if

// File: hw/gie_alu.sv
`timescale 1ns/1ps
module giei_alu (
  // Link from the decode
  giei_alu_if.alu port_a
);
  always_comb begin
    port_a.status_out = port_a.status_in;
    if (port_a.do_clr) begin
      port_a.status_out = port_a.status_in & giei_pkg::IRQ_CLR_MASK;
    end else if (port_a.do_set) begin
      port_a.status_out = port_a.status_in | giei_pkg::IRQ_EN_MASK;
    end
  end
endmodule : giei_alu

// File: hw/gie_instr.sv
// How it works
// - Disable ANDs the status word with FFF7h and writes it back, clearing the enable bit.
// - Disable leaves the arithmetic flags and the oscillator-off and core-off bits alone.
// - Enable ORs the status word with 0008h and writes it back, setting the enable bit.
// - Enable leaves the arithmetic flags and the oscillator-off and core-off bits alone.
// - Gated interrupt requests are refused while the global enable bit is clear.
// - After enable the next instruction always runs before any interrupt is taken.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
module giei_instr (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  // Instruction stream, one pulse per executed step
  input  wire logic                      instr_done,
  input  wire logic                      disable_irq_instruction,
  input  wire logic                      enable_irq_instruction,
  // Status word write port from the rest of the core
  input  wire logic                      status_wr,
  input  wire logic [giei_pkg::SW_W-1:0] status_wdata,
  // Interrupt side
  input  wire logic                      irq_pending,
  output logic                           irq_accept,
  // Status word view
  output logic [giei_pkg::SW_W-1:0]      status_word,
  output logic                           global_irq_enable
);

  // One status word register and one shadow tracker make up all the state;
  // the decode, the bit unit and the acceptance gate are combinational.
  // Limitation: only whether a request may be taken is decided here; vector,
  // priority and stacking belong to the interrupt controller

  // Interrupt shadow after enable
  typedef enum logic [1:0] {
    SHD_IDLE = 2'h1,
    SHD_HOLD = 2'h2
  } giei_shadow_t;

  // Where the next status word comes from
  typedef enum logic [2:0] {
    SRC_KEEP  = 3'h1,
    SRC_ALU   = 3'h2,
    SRC_WRITE = 3'h4
  } giei_src_t;

  // Link to the bit operation unit
  giei_alu_if                alu_link ();

  // Decode
  giei_pkg::giei_op_t        op;
  giei_src_t                 src;

  // Status word state
  logic [giei_pkg::SW_W-1:0] next_status;

  // Shadow state
  giei_shadow_t              shadow_state;
  giei_shadow_t              next_shadow_state;

  // Shadow controls
  logic                      arm_shadow;
  logic                      release_shadow;

  // Acceptance terms
  logic                      at_boundary;
  logic                      request_live;
  logic                      enable_open;
  logic                      shadow_free;

  // Bit operation unit: clear or set of the enable bit only
  giei_alu u_alu (
    .port_a (alu_link)
  );

  // Instruction decode; disable wins if both strobes ever meet, the safe side
  always_comb begin
    op = giei_pkg::OP_NONE;
    unique case ({disable_irq_instruction, enable_irq_instruction})
      2'h0: begin
        op = giei_pkg::OP_NONE;
      end
      2'h1: begin
        op = giei_pkg::OP_SET;
      end
      2'h2: begin
        op = giei_pkg::OP_CLR;
      end
      2'h3: begin
        op = giei_pkg::OP_CLR;
      end
    endcase
  end

  // The unit sees the registered word and the one operation in flight
  assign alu_link.status_in = status_word;
  assign alu_link.do_clr    = (op == giei_pkg::OP_CLR);
  assign alu_link.do_set    = (op == giei_pkg::OP_SET);

  // Source select; a plain status write in the same cycle loses to the
  // instruction, so the instruction's own result is never overwritten.
  // Each cycle carries at most one of the three sources
  always_comb begin
    src = SRC_KEEP;
    unique case (op)
      giei_pkg::OP_CLR: begin
        src = SRC_ALU;
      end
      giei_pkg::OP_SET: begin
        src = SRC_ALU;
      end
      giei_pkg::OP_NONE: begin
        if (status_wr) begin
          src = SRC_WRITE;
        end else begin
          src = SRC_KEEP;
        end
      end
    endcase
  end

  // Next status word
  always_comb begin
    next_status = status_word;
    unique case (src)
      SRC_KEEP: begin
        next_status = status_word;
      end
      SRC_ALU: begin
        // Only the enable bit is taken from the unit; the rest is held here so
        // the arithmetic and mode bits survive whatever the unit returns
        next_status = (status_word & giei_pkg::IRQ_CLR_MASK)
                      | (alu_link.status_out & giei_pkg::IRQ_EN_MASK);
      end
      SRC_WRITE: begin
        // A general write may move the enable bit too, but opens no shadow
        next_status = status_wdata;
      end
    endcase
  end

  // Status word register; reset clears the enable bit, so nothing is taken
  // before software has run an enable or written the bit through the status port
  always_ff @(posedge core_clk) begin
    if (srst) begin
      status_word <= giei_pkg::STATUS_RST;
    end else begin
      status_word <= next_status;
    end
  end

  // The flag is a plain view of the registered word, so it changes on the same
  // edge as the word, at the end of the instruction's cycle, and not a cycle later
  assign global_irq_enable = status_word[giei_pkg::IRQ_EN_BIT];

  // Shadow controls; arming wins over release in the same cycle
  assign arm_shadow     = (op == giei_pkg::OP_SET);
  assign release_shadow = instr_done;

  // Shadow: armed by enable, released by the boundary of the next
  // instruction; the enable step's own boundary does not release it
  always_comb begin
    next_shadow_state = shadow_state;
    unique case (shadow_state)
      SHD_IDLE: begin
        if (arm_shadow) begin
          next_shadow_state = SHD_HOLD;
        end
      end
      SHD_HOLD: begin
        if (arm_shadow) begin
          next_shadow_state = SHD_HOLD;
        end else if (release_shadow) begin
          next_shadow_state = SHD_IDLE;
        end
      end
      default: begin
        // An upset code falls back to idle rather than locking interrupts out
        next_shadow_state = SHD_IDLE;
      end
    endcase
  end

  // Shadow register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shadow_state <= SHD_IDLE;
    end else begin
      shadow_state <= next_shadow_state;
    end
  end

  // Acceptance terms; requests are only taken between instructions
  assign at_boundary  = instr_done;
  assign request_live = irq_pending;
  assign enable_open  = global_irq_enable;
  // The enable step itself is blocked as well: the shadow register only
  // holds from the following cycle
  assign shadow_free  = (shadow_state == SHD_IDLE) && !arm_shadow;

  // Disable opens no shadow: a request can still be taken at its own
  // boundary, which is why software keeps one instruction of distance.
  // Kept combinational so the boundary sees the flag with no added cycle,
  // at the cost of a longer path from the pending request
  always_comb begin
    irq_accept = 1'h0;
    if (!at_boundary) begin
      irq_accept = 1'h0;
    end else if (!request_live) begin
      irq_accept = 1'h0;
    end else if (!enable_open) begin
      irq_accept = 1'h0;
    end else if (!shadow_free) begin
      irq_accept = 1'h0;
    end else begin
      irq_accept = 1'h1;
    end
  end

endmodule : giei_instr

// File: verif/gie_checker.sv
`timescale 1ns/1ps
module giei_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        srst,
  // Instruction stream
  input wire logic        instr_done,
  input wire logic        disable_irq_instruction,
  input wire logic        enable_irq_instruction,
  // Interrupt side
  input wire logic        irq_pending,
  input wire logic        irq_accept,
  // Status word view
  input wire logic [15:0] status_word,
  input wire logic        global_irq_enable
);
  wire d = disable_irq_instruction;
  wire e = enable_irq_instruction;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_dis_clr: assert property (d |=>
    status_word == ($past(status_word) & 16'hFFF7)) else $error("disable result");
  a_en_set: assert property (e |=>
    status_word == ($past(status_word) | 16'h0008)) else $error("enable result");
  a_gate_off: assert property (!global_irq_enable |-> !irq_accept)
    else $error("accept while gated");
  a_shadow_hold: assert property (e ##1 instr_done |-> !irq_accept)
    else $error("accept in shadow");
  a_enable_block: assert property (e |-> !irq_accept)
    else $error("accept in enable cycle");
  a_accept_boundary: assert property (irq_accept |-> instr_done && irq_pending)
    else $error("accept off boundary");
  a_flag_mirror: assert property (global_irq_enable == status_word[3])
    else $error("enable flag differs from word");
  a_dis_low: assert property (d |=> !global_irq_enable)
    else $error("enable flag set after disable");
  c_acc: cover property (irq_accept);
  c_en: cover property (e ##1 instr_done);
  c_dis: cover property (d && irq_accept);
endmodule : giei_checker
bind giei_instr giei_checker u_chk (
  .core_clk                (core_clk),
  .srst                    (srst),
  .instr_done              (instr_done),
  .disable_irq_instruction (disable_irq_instruction),
  .enable_irq_instruction  (enable_irq_instruction),
  .irq_pending             (irq_pending),
  .irq_accept              (irq_accept),
  .status_word             (status_word),
  .global_irq_enable       (global_irq_enable)
);

// File: verif/global_irq_enable_instr_tb.sv
`timescale 1ns/1ps
module global_irq_enable_instr_tb;
  logic        core_clk     = 1'h0;
  logic        srst         = 1'h1;
  logic        instr_done   = 1'h0;
  logic        status_wr    = 1'h0;
  logic        irq_pending  = 1'h0;
  logic        d            = 1'h0;
  logic        e            = 1'h0;
  logic [15:0] status_wdata = 16'h0000;
  logic        irq_accept;
  logic        global_irq_enable;
  logic [15:0] status_word;
  int          seed         = 34;
  int          miscompares  = 0;
  int          tests_run    = 0;
  int          m            = 0;
  int          sh           = 0;
  int          n            = 0;
  int          r            = 0;
  giei_instr u_dut (
    .core_clk                (core_clk),
    .srst                    (srst),
    .instr_done              (instr_done),
    .disable_irq_instruction (d),
    .enable_irq_instruction  (e),
    .status_wr               (status_wr),
    .status_wdata            (status_wdata),
    .irq_pending             (irq_pending),
    .irq_accept              (irq_accept),
    .status_word             (status_word),
    .global_irq_enable       (global_irq_enable)
  );
  always #2.5 core_clk = ~core_clk;
  // 3000 cycles of 5 ns, reset included, plus margin; a hang ends here as a failure
  initial #20000 conclude(1);
  task cmp_word(input logic [15:0] g, input logic [15:0] x);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : cmp_word
  task cmp_bit(input logic g, input logic x);
    tests_run++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask : cmp_bit
  task conclude(input int t);
    miscompares += t;
    $display("counts: %0d checks, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // Model state is read before this edge's updates land
  always @(posedge core_clk) begin
    r = int'(irq_pending && m[3] && instr_done && sh == 0 && !e);
    if (!srst) cmp_word(status_word, m[15:0]);
    if (!srst) cmp_bit(irq_accept, r[0]);
    if (!srst) cmp_bit(global_irq_enable, m[3]);
    sh = srst ? 0 : e ? 1 : instr_done ? 0 : sh;
    m = srst ? 0 : d ? m & 32'hFFF7 : e ? m | 32'h0008 : status_wr ? int'(status_wdata) : m;
    n++;
    // Reset for 16 cycles at the start and once more in mid-run
    srst <= (n < 16) || (n >= 1500 && n < 1502);
    r = $random(seed);
    {instr_done, irq_pending, status_wr, status_wdata} <= {|r[1:0], r[8], ~|r[7:5], r[31:16]};
    // Disable is never padded by a nop, so accepts at its own boundary are exercised
    {d, e} <= {~|r[4:2], r[4:2] == 3'h1};
    if (n == 3000) $display("test random_mix ended after %0d cycles", n);
    if (n == 3000) conclude(0);
  end
endmodule : global_irq_enable_instr_tb
